// File: rpc_pkg.sv
// package for the root port capabilities register block
// assumes a single AHB-Lite slave with 32-bit data on hclk
package rpc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ROOT_PORT_CAPABILITIES_IDX = 8'h92; // printed index
    localparam logic [9:0] ROOT_PORT_CAPABILITIES_ADDR = 10'h248; // byte address, index times four
    localparam int ADDR_BITS = 10; // decoded address width
    // field positions
    localparam int POWER_GOOD_WAIT_TIME_LSB = 24;
    localparam int OVERCURRENT_REPORTING_ABSENT_BIT = 12;
    localparam int OVERCURRENT_PER_PORT_SELECT_BIT = 11;
    localparam int COMPOUND_DEVICE_FLAG_BIT = 10;
    localparam int POWER_SWITCHING_ABSENT_BIT = 9;
    localparam int PER_PORT_SWITCHING_SELECT_BIT = 8;
    // reset values
    localparam logic [7:0] POWER_GOOD_WAIT_TIME_RST = 8'hFF;
    localparam logic OVERCURRENT_PER_PORT_SELECT_RST = 1'b1;
    localparam logic PER_PORT_SWITCHING_SELECT_RST = 1'b1;
    localparam logic [1:0] DOWNSTREAM_PORT_COUNT_VAL = 2'h2;
    // timing: unit of the wait field
    localparam int POWER_GOOD_UNIT_MS = 2;
    localparam int CLK_MHZ = 250;
    localparam int POWER_GOOD_UNIT_CYCLES = POWER_GOOD_UNIT_MS * 1000 * CLK_MHZ;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] power_good_wait_time; // wait in 2 ms units
        logic overcurrent_reporting_absent; // no overcurrent reporting
        logic overcurrent_per_port_select; // per-port overcurrent report
        logic power_switching_absent; // ports always powered
        logic per_port_switching_select; // per-port power switching
    } rpc_cfg_t;

    typedef struct packed {
        logic valid; // a word write is pending
        logic [ADDR_BITS-1:0] addr; // latched byte address
    } rpc_wph_t;

    typedef enum logic [1:0] {
        RPC_PWR_IDLE,
        RPC_PWR_WAIT,
        RPC_PWR_GOOD
    } rpc_pwr_state_t;
endpackage : rpc_pkg

// File: rpc_root_port_caps.sv
// root port capabilities register with its power and overcurrent steering
// assumes an AHB-Lite master, one slave, hready driven by this hreadyout
//
// Overview of operation
// (RULE_01) eight-bit power-good wait, units of 2 ms
// (RULE_02) reporting-absent set disables all overcurrent reporting
// (RULE_03) select 0 collective, select 1 per port
// (RULE_04) software aligns overcurrent select with switching mode
// (RULE_05) compound device flag reads zero, read only
// (RULE_06) switching-absent keeps every port powered
// (RULE_07) switching select 0 powers ports together
// (RULE_08) select 1: mask picks per-port or global command
// (RULE_09) port count field reads two, read only
// (RULE_10) full-word access allowed in any state
// (RULE_11) reset loads wait ones, selects one, count two
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module rpc_root_port_caps
    import rpc_pkg::*;
#(
    parameter int NUM_PORTS = 2, // downstream ports served
    parameter int UNIT_CYCLES = POWER_GOOD_UNIT_CYCLES // cycles per 2 ms step
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic [NUM_PORTS-1:0] port_power_mask, // per-port power mask
    input wire logic global_power_on, // global set power command
    input wire logic global_power_off, // global clear power command
    input wire logic [NUM_PORTS-1:0] port_power_on, // per-port set power command
    input wire logic [NUM_PORTS-1:0] port_power_off, // per-port clear power command
    input wire logic [NUM_PORTS-1:0] port_overcurrent, // raw overcurrent sense
    output logic [NUM_PORTS-1:0] port_power, // port power enables
    output logic [NUM_PORTS-1:0] port_power_good, // power settled per port
    output logic global_overcurrent, // collective overcurrent report
    output logic [NUM_PORTS-1:0] port_overcurrent_report // per-port overcurrent report
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    rpc_cfg_t cfg; // writable fields
    rpc_cfg_t next_cfg;
    rpc_wph_t wph; // pending write data phase
    rpc_wph_t next_wph;
    logic [31:0] next_hrdata;
    logic [31:0] reg_view; // register as read
    logic take; // address phase taken
    logic hit; // address decodes to the register

    // assemble the read view, reserved bits zero
    always_comb begin
        reg_view = 32'h0000_0000;
        reg_view[POWER_GOOD_WAIT_TIME_LSB +: 8] = cfg.power_good_wait_time; // RULE_01
        reg_view[OVERCURRENT_REPORTING_ABSENT_BIT] = cfg.overcurrent_reporting_absent;
        reg_view[OVERCURRENT_PER_PORT_SELECT_BIT] = cfg.overcurrent_per_port_select;
        reg_view[COMPOUND_DEVICE_FLAG_BIT] = 1'b0; // RULE_05
        reg_view[POWER_SWITCHING_ABSENT_BIT] = cfg.power_switching_absent;
        reg_view[PER_PORT_SWITCHING_SELECT_BIT] = cfg.per_port_switching_select;
        reg_view[1:0] = DOWNSTREAM_PORT_COUNT_VAL; // RULE_09
    end

    // decode address phase and apply write data phase
    always_comb begin
        take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
        hit = (haddr[ADDR_BITS-1:0] == ROOT_PORT_CAPABILITIES_ADDR)
            && (haddr[31:ADDR_BITS] == '0);
        next_cfg = cfg;
        next_hrdata = 32'h0000_0000; // unmapped reads return zero
        // write lands regardless of controller state, whole word
        if (wph.valid && wph.addr == ROOT_PORT_CAPABILITIES_ADDR) begin // RULE_10
            next_cfg.power_good_wait_time = hwdata[POWER_GOOD_WAIT_TIME_LSB +: 8];
            next_cfg.overcurrent_reporting_absent = hwdata[OVERCURRENT_REPORTING_ABSENT_BIT];
            next_cfg.overcurrent_per_port_select = hwdata[OVERCURRENT_PER_PORT_SELECT_BIT];
            next_cfg.power_switching_absent = hwdata[POWER_SWITCHING_ABSENT_BIT];
            next_cfg.per_port_switching_select = hwdata[PER_PORT_SWITCHING_SELECT_BIT];
        end
        next_wph.valid = take && hwrite && hit && (hsize == HSIZE_WORD);
        next_wph.addr = haddr[ADDR_BITS-1:0];
        // read data registered for the data phase
        if (take && !hwrite && hit) begin // RULE_10
            next_hrdata = reg_view;
        end else if (!take) begin
            next_hrdata = hrdata; // hold while idle
        end
    end

    // register the bus state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.power_good_wait_time <= POWER_GOOD_WAIT_TIME_RST; // RULE_11
            cfg.overcurrent_reporting_absent <= 1'b0;
            cfg.overcurrent_per_port_select <= OVERCURRENT_PER_PORT_SELECT_RST; // RULE_11
            cfg.power_switching_absent <= 1'b0;
            cfg.per_port_switching_select <= PER_PORT_SWITCHING_SELECT_RST; // RULE_11
            wph <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            cfg <= next_cfg;
            wph <= next_wph;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1; // zero wait states
            hresp <= 1'b0; // okay
        end
    end

    // ------------------------------------------------------------
    // port power switching
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] next_port_power;

    // each port follows the command source that the mode selects
    always_comb begin
        next_port_power = port_power;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (cfg.power_switching_absent) begin
                next_port_power[i] = 1'b1; // RULE_06
            end else if (!cfg.per_port_switching_select || !port_power_mask[i]) begin
                // ganged, or masked off: only global commands act
                if (global_power_on) begin // RULE_07
                    next_port_power[i] = 1'b1;
                end else if (global_power_off) begin
                    next_port_power[i] = 1'b0;
                end
            end else begin
                // per-port mode with mask set: only port commands act
                if (port_power_on[i]) begin // RULE_08
                    next_port_power[i] = 1'b1;
                end else if (port_power_off[i]) begin
                    next_port_power[i] = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // power-good wait per port
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] next_port_power_good;
    rpc_pwr_state_t pwr_state [NUM_PORTS];
    rpc_pwr_state_t next_pwr_state [NUM_PORTS];
    logic [31:0] unit_cnt [NUM_PORTS]; // cycles inside one 2 ms step
    logic [31:0] next_unit_cnt [NUM_PORTS];
    logic [7:0] step_cnt [NUM_PORTS]; // 2 ms steps elapsed
    logic [7:0] next_step_cnt [NUM_PORTS];

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            // wait wait-field times 2 ms after power comes on
            always_comb begin
                next_pwr_state[g] = pwr_state[g];
                next_unit_cnt[g] = unit_cnt[g];
                next_step_cnt[g] = step_cnt[g];
                next_port_power_good[g] = 1'b0;
                case (pwr_state[g])
                    RPC_PWR_IDLE: begin
                        next_unit_cnt[g] = 32'h0000_0000;
                        next_step_cnt[g] = 8'h00;
                        if (next_port_power[g]) begin
                            next_pwr_state[g] = RPC_PWR_WAIT;
                        end
                    end
                    RPC_PWR_WAIT: begin
                        if (!next_port_power[g]) begin
                            next_pwr_state[g] = RPC_PWR_IDLE;
                        end else if (step_cnt[g] >= cfg.power_good_wait_time) begin // RULE_01
                            next_pwr_state[g] = RPC_PWR_GOOD;
                            next_port_power_good[g] = 1'b1;
                        end else if (unit_cnt[g] == 32'(UNIT_CYCLES - 1)) begin
                            next_unit_cnt[g] = 32'h0000_0000;
                            next_step_cnt[g] = step_cnt[g] + 8'h01;
                        end else begin
                            next_unit_cnt[g] = unit_cnt[g] + 32'h0000_0001;
                        end
                    end
                    RPC_PWR_GOOD: begin
                        next_port_power_good[g] = next_port_power[g];
                        if (!next_port_power[g]) begin
                            next_pwr_state[g] = RPC_PWR_IDLE;
                        end
                    end
                    default: begin
                        next_pwr_state[g] = RPC_PWR_IDLE;
                    end
                endcase
            end

            // register the wait state
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pwr_state[g] <= RPC_PWR_IDLE;
                    unit_cnt[g] <= 32'h0000_0000;
                    step_cnt[g] <= 8'h00;
                end else begin
                    pwr_state[g] <= next_pwr_state[g];
                    unit_cnt[g] <= next_unit_cnt[g];
                    step_cnt[g] <= next_step_cnt[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // overcurrent reporting
    // ------------------------------------------------------------
    logic next_global_overcurrent;
    logic [NUM_PORTS-1:0] next_port_overcurrent_report;

    // route sense to collective or per-port report, or suppress it
    always_comb begin
        next_global_overcurrent = 1'b0;
        next_port_overcurrent_report = '0;
        if (!cfg.overcurrent_reporting_absent) begin // RULE_02
            if (cfg.overcurrent_per_port_select) begin // RULE_03
                next_port_overcurrent_report = port_overcurrent;
            end else begin
                next_global_overcurrent = |port_overcurrent; // RULE_03
            end
        end
    end

    // register power and report outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_power <= '0;
            port_power_good <= '0;
            global_overcurrent <= 1'b0;
            port_overcurrent_report <= '0;
        end else begin
            port_power <= next_port_power;
            port_power_good <= next_port_power_good;
            global_overcurrent <= next_global_overcurrent;
            port_overcurrent_report <= next_port_overcurrent_report;
        end
    end
endmodule : rpc_root_port_caps

// File: rpc_root_port_caps_asserts.sv
// checker for the root port capabilities block, ports only
// assumes one AHB-Lite master and hready tied to hreadyout
`timescale 1ns/1ns
module rpc_root_port_caps_asserts
    import rpc_pkg::*;
#(
    parameter int NUM_PORTS = 2 // downstream ports served
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [NUM_PORTS-1:0] port_power_mask, // per-port mask
    input wire logic global_power_on, // global set
    input wire logic global_power_off, // global clear
    input wire logic [NUM_PORTS-1:0] port_power_on, // per-port set
    input wire logic [NUM_PORTS-1:0] port_power_off, // per-port clear
    input wire logic [NUM_PORTS-1:0] port_overcurrent, // raw sense
    input wire logic [NUM_PORTS-1:0] port_power, // power enables
    input wire logic [NUM_PORTS-1:0] port_power_good, // power settled
    input wire logic global_overcurrent, // collective report
    input wire logic [NUM_PORTS-1:0] port_overcurrent_report // per-port report
);
    localparam logic [31:0] REG_A = {22'h0, ROOT_PORT_CAPABILITIES_ADDR};
    localparam rpc_cfg_t CFG_RST = '{POWER_GOOD_WAIT_TIME_RST, 1'b0,
        OVERCURRENT_PER_PORT_SELECT_RST, 1'b0, PER_PORT_SWITCHING_SELECT_RST};
    wire logic take = hsel && hready && htrans[1]; // address phase accepted
    logic wr_pend; // word write to the register in data phase
    logic rd_q; // register read answered this cycle
    rpc_cfg_t cfg; // shadow of the writable fields
    rpc_cfg_t cfg_d; // shadow one cycle late, the view a read samples
    // shadow tracks writes as they land at the end of the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_q <= 1'b0;
            cfg <= CFG_RST;
            cfg_d <= CFG_RST;
        end else begin
            wr_pend <= take && hwrite && hsize == HSIZE_WORD && haddr == REG_A;
            rd_q <= take && !hwrite && haddr == REG_A;
            if (wr_pend) begin
                cfg <= '{hwdata[31:24], hwdata[12], hwdata[11], hwdata[9], hwdata[8]};
            end
            cfg_d <= cfg;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_okay_a: assert property (take |=> hreadyout && !hresp)
        else $error("slave not ready or not okay");
    read_word_a: assert property (rd_q |-> hrdata == {cfg_d.power_good_wait_time, 11'h0,
        cfg_d.overcurrent_reporting_absent, cfg_d.overcurrent_per_port_select, 1'b0,
        cfg_d.power_switching_absent, cfg_d.per_port_switching_select, 6'h0,
        DOWNSTREAM_PORT_COUNT_VAL}) else $error("register read word wrong");
    oc_absent_a: assert property (cfg.overcurrent_reporting_absent |=>
        !global_overcurrent && port_overcurrent_report == '0) else $error("report while absent");
    oc_collect_a: assert property (!cfg.overcurrent_reporting_absent &&
        !cfg.overcurrent_per_port_select |=> global_overcurrent == |$past(port_overcurrent))
        else $error("collective report wrong");
    oc_port_a: assert property (!cfg.overcurrent_reporting_absent &&
        cfg.overcurrent_per_port_select |=> port_overcurrent_report == $past(port_overcurrent))
        else $error("per-port report wrong");
    always_on_a: assert property (cfg.power_switching_absent |=> &port_power)
        else $error("port unpowered while switching absent");
    ganged_on_a: assert property (!cfg.power_switching_absent &&
        !cfg.per_port_switching_select && global_power_on |=> &port_power)
        else $error("ganged power on missed");
    masked_port_a: assert property (!cfg.power_switching_absent &&
        cfg.per_port_switching_select && port_power_mask[0] && port_power_on[0] |=> port_power[0])
        else $error("masked port missed its command");
    unmasked_port_a: assert property (!cfg.power_switching_absent &&
        cfg.per_port_switching_select && !port_power_mask[1] && !global_power_on &&
        !global_power_off |=> $stable(port_power[1])) else $error("unmasked port moved");
    good_lag_a: assert property ($rose(port_power[0]) |-> !port_power_good[0])
        else $error("power good with no wait");
    cover property (wr_pend);
    cover property (cfg.overcurrent_reporting_absent && port_overcurrent != '0);
    cover property ($rose(port_power_good[0]));
endmodule : rpc_root_port_caps_asserts

// File: tb_top.sv
// testbench for the root port capabilities block
// assumes the bench is the only AHB-Lite master; hready is hreadyout
`timescale 1ns/1ns
module tb_top;
    import rpc_pkg::*;
    localparam logic [31:0] A = {22'h0, ROOT_PORT_CAPABILITIES_ADDR}; // register address
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, global_power_on, global_power_off;
    logic global_overcurrent;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, port_power_mask, port_power_on, port_power_off, port_overcurrent;
    logic [1:0] port_power, port_power_good, port_overcurrent_report;
    logic [2:0] hsize;
    wire logic hready = hreadyout; // single slave
    int n_errors = 0;
    int checks = 0;
    typedef struct {logic [31:0] w; logic [31:0] e;} rpc_row_t;
    rpc_row_t rows [5] = '{'{32'hFFFFFFFF, 32'hFF001B02}, '{32'h00000000, 32'h00000002},
        '{32'hA5FFE4FC, 32'hA5000002}, '{32'h5A001300, 32'h5A001302},
        '{32'h00000802, 32'h00000802}};
    rpc_root_port_caps #(.NUM_PORTS(2), .UNIT_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_power_mask(port_power_mask), .global_power_on(global_power_on),
        .global_power_off(global_power_off), .port_power_on(port_power_on),
        .port_power_off(port_power_off), .port_overcurrent(port_overcurrent),
        .port_power(port_power), .port_power_good(port_power_good),
        .global_overcurrent(global_overcurrent),
        .port_overcurrent_report(port_overcurrent_report));
    // 250 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic finish_test;
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single transfer: address phase, then data phase, each held until hready
    task automatic xfer(input logic wr, input logic [31:0] a, d, input logic [2:0] sz);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr; hsize <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] d);
        xfer(1'b1, A, d, HSIZE_WORD);
    endtask : wr
    task automatic rdchk(input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0, HSIZE_WORD);
        chk(rd, e);
    endtask : rdchk
    // one-cycle power command, then settle and stop mid-cycle for sampling
    task automatic pwr(input logic on, off, input logic [1:0] pon, poff);
        @(posedge hclk);
        global_power_on <= on;
        global_power_off <= off;
        port_power_on <= pon;
        port_power_off <= poff;
        @(posedge hclk);
        global_power_on <= 1'b0;
        global_power_off <= 1'b0;
        port_power_on <= 2'b0;
        port_power_off <= 2'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask : pwr
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = HSIZE_WORD;
        hwdata = '0; global_power_on = 1'b0; global_power_off = 1'b0; port_power_on = '0;
        port_power_off = '0; port_power_mask = 2'b01; port_overcurrent = 2'b10;
        @(posedge hclk);
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].w);
            rdchk(A, rows[i].e);
        end
        xfer(1'b1, A + 32'h4, 32'hFFFFFFFF, HSIZE_WORD); // unmapped write is ignored
        xfer(1'b1, A, 32'hFFFFFFFF, 3'h0); // byte write is ignored
        rdchk(A, 32'h00000802);
        rdchk(A + 32'h4, 32'h0);
        wr(32'h00000100);
        wr(32'h00000900);
        pwr(1'b0, 1'b0, 2'b0, 2'b0);
        chk(port_overcurrent_report, 2'b10);
        wr(32'h00000100);
        pwr(1'b0, 1'b0, 2'b0, 2'b0);
        chk(global_overcurrent, 1'b1);
        wr(32'h00001900);
        pwr(1'b0, 1'b0, 2'b0, 2'b0);
        chk({global_overcurrent, port_overcurrent_report}, 3'h0);
        wr(32'h00000000);
        pwr(1'b0, 1'b1, 2'b0, 2'b0);
        chk(port_power, 2'b00);
        pwr(1'b1, 1'b0, 2'b0, 2'b0);
        chk(port_power, 2'b11);
        pwr(1'b0, 1'b0, 2'b0, 2'b0);
        chk(port_power_good, 2'b11);
        wr(32'h02000000);
        pwr(1'b0, 1'b1, 2'b0, 2'b0);
        pwr(1'b1, 1'b0, 2'b0, 2'b0);
        chk(port_power_good, 2'b00);
        repeat (30) @(posedge hclk);
        chk(port_power_good, 2'b11);
        wr(32'h00000100);
        pwr(1'b0, 1'b1, 2'b0, 2'b0);
        chk(port_power, 2'b01);
        pwr(1'b0, 1'b0, 2'b10, 2'b0);
        chk(port_power, 2'b01);
        pwr(1'b0, 1'b0, 2'b0, 2'b01);
        chk(port_power, 2'b00);
        pwr(1'b1, 1'b0, 2'b0, 2'b0);
        chk(port_power, 2'b10);
        pwr(1'b0, 1'b0, 2'b01, 2'b0);
        chk(port_power, 2'b11);
        wr(32'h00000300);
        pwr(1'b0, 1'b1, 2'b0, 2'b11);
        chk(port_power, 2'b11);
        @(posedge hclk);
        do_reset();
        chk(port_power, 2'b00);
        rdchk(A, 32'hFF000902);
        chk({30'h0, rd[1:0]}, {30'h0, DOWNSTREAM_PORT_COUNT_VAL});
        chk({30'h0, hreadyout, hresp}, 32'h00000002);
        finish_test();
    end
    // cut a hang short
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        finish_test();
    end
endmodule : tb_top
bind rpc_root_port_caps rpc_root_port_caps_asserts #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_power_mask(port_power_mask),
    .global_power_on(global_power_on), .global_power_off(global_power_off),
    .port_power_on(port_power_on), .port_power_off(port_power_off),
    .port_overcurrent(port_overcurrent), .port_power(port_power),
    .port_power_good(port_power_good), .global_overcurrent(global_overcurrent),
    .port_overcurrent_report(port_overcurrent_report));
